// *** core/cbi_top.sv ***
// Command block interpreter: host command port, framing and APB registers
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module cbi_top (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_host_wr,
  input  wire logic [7:0]  i_host_wdata,
  input  wire logic        i_host_rd,
  output logic      [7:0]  o_host_rdata,
  input  wire logic        i_host_sync_flag_a,
  input  wire logic        i_host_sync_flag_b,
  output logic             o_adapter_sync_flag_a,
  output logic             o_adapter_sync_flag_b,
  output logic             o_host_cmd_full,
  output logic             o_adapter_cmd_empty,
  output logic             o_cmd_valid,
  output logic      [7:0]  o_cmd_code,
  output logic      [7:0]  o_cmd_len,
  output logic             o_cmd_no_resp,
  output logic             o_irq
);
  logic [1:0] host_sf;
  assign host_sf = {i_host_sync_flag_b, i_host_sync_flag_a};

  // Host to adapter byte register
  logic       hcf_reg;
  logic [7:0] hbyte_reg;
  logic       take;
  cbi_pkg::cbi_rx_type rx_reg;
  logic [7:0] code_reg, len_reg, cnt_reg, got_reg, total_reg;
  logic [1:0] asf_reg;
  logic       code_ok, no_resp;
  logic [5:0] wptr;
  logic [7:0] buf_rd;
  logic       bad_reg;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      hcf_reg   <= 1'b0;
      hbyte_reg <= 8'h00;
    end else if (i_host_wr) begin
      hcf_reg   <= 1'b1;
      hbyte_reg <= i_host_wdata;
    end else if (take) begin
      hcf_reg   <= 1'b0;
    end
  end

  // Interpreter drains the byte whenever it is full
  assign take = hcf_reg;

  cbi_rx_buf u_buf (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_wr     (take),
    .i_data   (hbyte_reg),
    .i_rd_idx (6'h00),
    .o_wr_ptr (wptr),
    .o_rd_data(buf_rd)
  );

  cbi_code_chk u_chk (
    .i_code   (code_reg),
    .o_valid  (code_ok),
    .o_no_resp(no_resp)
  );

  logic ev_acc, ev_rej;
  logic fin;
  assign fin = (rx_reg == cbi_pkg::RX_WAITEND) && host_sf == cbi_pkg::SF_END;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rx_reg    <= cbi_pkg::RX_IDLE;
      code_reg  <= 8'h00;
      len_reg   <= 8'h00;
      cnt_reg   <= 8'h00;
      got_reg   <= 8'h00;
      total_reg <= 8'h00;
      bad_reg   <= 1'b0;
    end else begin
      if (take && rx_reg != cbi_pkg::RX_WAITEND)
        got_reg <= got_reg + 8'h01;
      case (rx_reg)
        cbi_pkg::RX_IDLE: begin
          if (take) begin
            code_reg <= hbyte_reg;
            got_reg  <= 8'h01;
            bad_reg  <= 1'b0;
            rx_reg   <= cbi_pkg::RX_LEN;
          end
        end
        cbi_pkg::RX_LEN: begin
          if (take) begin
            len_reg <= hbyte_reg;
            cnt_reg <= 8'h00;
            if (hbyte_reg > cbi_pkg::MAX_PAYLOAD)
              bad_reg <= 1'b1;
            rx_reg <= (hbyte_reg == 8'h00) ? cbi_pkg::RX_TOTAL
                                            : cbi_pkg::RX_DATA;
          end
        end
        cbi_pkg::RX_DATA: begin
          if (take) begin
            cnt_reg <= cnt_reg + 8'h01;
            if (cnt_reg + 8'h01 == len_reg)
              rx_reg <= cbi_pkg::RX_TOTAL;
          end
        end
        cbi_pkg::RX_TOTAL: begin
          if (take) begin
            total_reg <= hbyte_reg;
            rx_reg    <= cbi_pkg::RX_WAITEND;
          end
        end
        cbi_pkg::RX_WAITEND: begin
          if (fin)
            rx_reg <= cbi_pkg::RX_IDLE;
        end
        default: rx_reg <= cbi_pkg::RX_IDLE;
      endcase
    end
  end

  // Total byte must equal bytes before it: code, length and payload
  logic good;
  assign good = !bad_reg && code_ok
                && (got_reg - 8'h01 <= cbi_pkg::MAX_BLOCK)
                && (total_reg == got_reg - 8'h01);
  assign ev_acc = fin && good;
  assign ev_rej = fin && !good;

  // Adapter to host send path
  cbi_pkg::cbi_tx_type tx_reg;
  logic       ace_reg;
  logic [7:0] abyte_reg;
  logic       send_wr, send_last;
  logic       ev_sent, ev_hnak;
  logic       sync_end_reg;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ace_reg   <= 1'b1;
      abyte_reg <= 8'h00;
    end else if (send_wr) begin
      ace_reg   <= 1'b0;
      abyte_reg <= i_pwdata[7:0];
    end else if (i_host_rd) begin
      ace_reg   <= 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n)
      sync_end_reg <= 1'b0;
    else if (send_last)
      sync_end_reg <= 1'b1;
    else if (tx_reg == cbi_pkg::TX_WAITACK &&
             (host_sf == cbi_pkg::SF_ACCEPT || host_sf == cbi_pkg::SF_REJECT))
      sync_end_reg <= 1'b0;
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n)
      tx_reg <= cbi_pkg::TX_IDLE;
    else begin
      case (tx_reg)
        cbi_pkg::TX_IDLE:    if (send_wr) tx_reg <= cbi_pkg::TX_BYTE;
        cbi_pkg::TX_BYTE:    if (send_last) tx_reg <= cbi_pkg::TX_WAITACK;
        cbi_pkg::TX_WAITACK: begin
          if (host_sf == cbi_pkg::SF_ACCEPT || host_sf == cbi_pkg::SF_REJECT)
            tx_reg <= cbi_pkg::TX_IDLE;
        end
        default: tx_reg <= cbi_pkg::TX_IDLE;
      endcase
    end
  end
  assign ev_sent = tx_reg == cbi_pkg::TX_WAITACK
                   && host_sf == cbi_pkg::SF_ACCEPT;
  assign ev_hnak = tx_reg == cbi_pkg::TX_WAITACK
                   && host_sf == cbi_pkg::SF_REJECT;

  // Adapter flags: answer end-of-block, mark end of own blocks
  always_ff @(posedge i_clock) begin
    if (!i_rst_n)
      asf_reg <= cbi_pkg::SF_NONE;
    else if (ev_acc)
      asf_reg <= cbi_pkg::SF_ACCEPT;
    else if (ev_rej)
      asf_reg <= cbi_pkg::SF_REJECT;
    else if (send_last)
      asf_reg <= cbi_pkg::SF_END;
    else if (sync_end_reg && (ev_sent || ev_hnak))
      asf_reg <= cbi_pkg::SF_NONE;
    else if (take && rx_reg == cbi_pkg::RX_IDLE)
      asf_reg <= cbi_pkg::SF_NONE;
  end

  // Completed command handed to adapter logic
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_cmd_valid   <= 1'b0;
      o_cmd_code    <= 8'h00;
      o_cmd_len     <= 8'h00;
      o_cmd_no_resp <= 1'b0;
    end else begin
      o_cmd_valid <= ev_acc;
      if (ev_acc) begin
        o_cmd_code    <= code_reg;
        o_cmd_len     <= len_reg;
        o_cmd_no_resp <= no_resp;
      end
    end
  end

  // APB slave, zero wait states
  localparam int N_EVW = cbi_pkg::N_EV;
  logic       wr_acc, rd_acc;
  logic [N_EVW-1:0] ist_reg, ien_reg;
  logic [N_EVW-1:0] ev_vec;
  logic       addr_ok;
  logic       code_err;

  assign wr_acc = i_psel && i_penable && i_pwrite;
  assign rd_acc = i_psel && i_penable && !i_pwrite;
  // A refused first code must not occupy the register
  assign send_wr = wr_acc && i_paddr == cbi_pkg::A_SEND && ace_reg
                   && !code_err;
  // Response codes 31..5f only, 34/35 originate transfers
  assign code_err = tx_reg == cbi_pkg::TX_IDLE &&
                    (i_pwdata[7:0] < cbi_pkg::AC_FIRST ||
                     i_pwdata[7:0] > cbi_pkg::AC_RSV_HI);
  assign send_last = wr_acc && i_paddr == cbi_pkg::A_SEND_CTL
                     && i_pwdata[0] && tx_reg == cbi_pkg::TX_BYTE;
  assign addr_ok = i_paddr == cbi_pkg::A_STATUS
                || i_paddr == cbi_pkg::A_INT_STAT
                || i_paddr == cbi_pkg::A_INT_EN
                || i_paddr == cbi_pkg::A_INT_CLR
                || i_paddr == cbi_pkg::A_LAST_CMD
                || i_paddr == cbi_pkg::A_SEND
                || i_paddr == cbi_pkg::A_SEND_CTL;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && (!addr_ok ||
                     (i_pwrite && i_paddr == cbi_pkg::A_SEND &&
                      (!ace_reg || code_err)));

  assign ev_vec = {ev_hnak, ev_sent, ev_rej, ev_acc};

  always_ff @(posedge i_clock) begin
    if (!i_rst_n)
      ien_reg <= '0;
    else if (wr_acc && i_paddr == cbi_pkg::A_INT_EN)
      ien_reg <= i_pwdata[N_EVW-1:0];
  end

  // Set wins over clear
  always_ff @(posedge i_clock) begin
    if (!i_rst_n)
      ist_reg <= '0;
    else if (wr_acc && i_paddr == cbi_pkg::A_INT_CLR)
      ist_reg <= (ist_reg & ~i_pwdata[N_EVW-1:0]) | ev_vec;
    else
      ist_reg <= ist_reg | ev_vec;
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n)
      o_irq <= 1'b0;
    else
      o_irq <= |((ist_reg | ev_vec) & ien_reg);
  end

  always_comb begin
    o_prdata = 32'h0000_0000;
    if (rd_acc) begin
      case (i_paddr)
        cbi_pkg::A_STATUS:   o_prdata = {16'h0000, 5'h00, rx_reg,
                               2'h0, tx_reg, asf_reg, hcf_reg, ace_reg};
        cbi_pkg::A_INT_STAT: o_prdata = {28'h0, ist_reg};
        cbi_pkg::A_INT_EN:   o_prdata = {28'h0, ien_reg};
        cbi_pkg::A_LAST_CMD: o_prdata = {16'h0000, len_reg, code_reg};
        default:             o_prdata = 32'h0000_0000;
      endcase
    end
  end

  assign o_host_rdata          = abyte_reg;
  assign o_adapter_sync_flag_a = asf_reg[0];
  assign o_adapter_sync_flag_b = asf_reg[1];
  assign o_host_cmd_full       = hcf_reg;
  assign o_adapter_cmd_empty   = ace_reg;

  // Assertions
  property p_hcf_set;
    @(posedge i_clock) disable iff (!i_rst_n)
      i_host_wr |=> o_host_cmd_full;
  endproperty
  a_hcf_set: assert property (p_hcf_set) else $error("full not set");

  property p_ace;
    @(posedge i_clock) disable iff (!i_rst_n)
      send_wr |=> !o_adapter_cmd_empty;
  endproperty
  a_ace: assert property (p_ace) else $error("empty not cleared");

  property p_ace_set;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_host_rd && !send_wr) |=> o_adapter_cmd_empty;
  endproperty
  a_ace_set: assert property (p_ace_set) else $error("empty not set");

  property p_ans;
    @(posedge i_clock) disable iff (!i_rst_n)
      fin |=> (asf_reg == cbi_pkg::SF_ACCEPT || asf_reg == cbi_pkg::SF_REJECT);
  endproperty
  a_ans: assert property (p_ans) else $error("end not answered");

  property p_only_end;
    @(posedge i_clock) disable iff (!i_rst_n)
      o_cmd_valid |-> $past(host_sf) == cbi_pkg::SF_END;
  endproperty
  a_only_end: assert property (p_only_end) else $error("early done");

  property p_rsv;
    @(posedge i_clock) disable iff (!i_rst_n)
      o_cmd_valid |-> o_cmd_code <= cbi_pkg::HC_LAST && o_cmd_code != 8'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved code accepted");

  property p_len;
    @(posedge i_clock) disable iff (!i_rst_n)
      o_cmd_valid |-> o_cmd_len <= cbi_pkg::MAX_PAYLOAD;
  endproperty
  a_len: assert property (p_len) else $error("payload too long");

  property p_idle;
    @(posedge i_clock) disable iff (!i_rst_n)
      (rx_reg == cbi_pkg::RX_IDLE && !take) |=> rx_reg == cbi_pkg::RX_IDLE;
  endproperty
  a_idle: assert property (p_idle) else $error("left idle alone");
endmodule

// *** core/cbi_pkg.sv ***
// Constants and types of the command block interpreter
package cbi_pkg;

  localparam logic [7:0] MAX_PAYLOAD = 8'h3e;
  localparam logic [7:0] MAX_BLOCK   = 8'h40;
  localparam int         BUF_DEPTH   = 64;

  localparam logic [1:0] SF_NONE   = 2'h0;
  localparam logic [1:0] SF_ACCEPT = 2'h1;
  localparam logic [1:0] SF_REJECT = 2'h2;
  localparam logic [1:0] SF_END    = 2'h3;

  localparam logic [7:0] HC_LAST   = 8'h11;
  localparam logic [7:0] HC_RSV_HI = 8'h2f;
  localparam logic [7:0] AC_FIRST  = 8'h31;
  localparam logic [7:0] AC_RSV_HI = 8'h5f;
  localparam logic [7:0] AC_DL_REQ = 8'h34;
  localparam logic [7:0] AC_UL_REQ = 8'h35;

  // APB map
  localparam logic [7:0] A_STATUS   = 8'h00;
  localparam logic [7:0] A_INT_STAT = 8'h04;
  localparam logic [7:0] A_INT_EN   = 8'h08;
  localparam logic [7:0] A_INT_CLR  = 8'h0c;
  localparam logic [7:0] A_LAST_CMD = 8'h10;
  localparam logic [7:0] A_SEND     = 8'h14;
  localparam logic [7:0] A_SEND_CTL = 8'h18;

  localparam int EV_ACCEPT = 0;
  localparam int EV_REJECT = 1;
  localparam int EV_SENT   = 2;
  localparam int EV_HOSTNK = 3;
  localparam int N_EV      = 4;

  typedef enum logic [2:0] {
    RX_IDLE, RX_LEN, RX_DATA, RX_TOTAL, RX_WAITEND
  } cbi_rx_type;

  typedef enum logic [1:0] {
    TX_IDLE, TX_BYTE, TX_WAITACK
  } cbi_tx_type;

endpackage

// *** core/cbi_rx_buf.sv ***
// Circular 64-byte store for incoming host block bytes
`timescale 1ns/1ps
module cbi_rx_buf (
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_data,
  input  wire logic [5:0] i_rd_idx,
  output logic      [5:0] o_wr_ptr,
  output logic      [7:0] o_rd_data
);
  logic [7:0] mem_reg [cbi_pkg::BUF_DEPTH];
  logic [5:0] ptr_reg;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n)
      ptr_reg <= 6'h00;
    else if (i_wr)
      ptr_reg <= ptr_reg + 6'h01;
  end

  genvar g;
  generate
    for (g = 0; g < cbi_pkg::BUF_DEPTH; g++) begin : g_ent
      always_ff @(posedge i_clock) begin
        if (i_wr && ptr_reg == 6'(g))
          mem_reg[g] <= i_data;
      end
    end
  endgenerate

  always_ff @(posedge i_clock) begin
    if (!i_rst_n)
      o_rd_data <= 8'h00;
    else
      o_rd_data <= mem_reg[i_rd_idx];
  end

  assign o_wr_ptr = ptr_reg;
endmodule

// *** core/cbi_code_chk.sv ***
// Classifies host command codes
`timescale 1ns/1ps
module cbi_code_chk (
  input  wire logic [7:0] i_code,
  output logic            o_valid,
  output logic            o_no_resp
);
  always_comb begin
    o_valid   = (i_code != 8'h00) && (i_code <= cbi_pkg::HC_LAST);
    o_no_resp = (i_code >= 8'h04) && (i_code <= 8'h07);
  end
endmodule

// *** tb/cbi_host_model.sv ***
// Host driver model: command register bytes and host sync flags
`timescale 1ns/1ps
module cbi_host_model (
  input  wire logic       i_clock,
  input  wire logic       i_full,
  input  wire logic [7:0] i_rdata,
  input  wire logic [1:0] i_asf,
  output logic            o_wr,
  output logic      [7:0] o_wdata,
  output logic            o_rd,
  output logic      [1:0] o_flags
);
  int   seed;
  logic saw_full;

  initial begin
    seed = 18;
    saw_full = 1'b0;
    o_wr = 1'b0;
    o_wdata = 8'h00;
    o_rd = 1'b0;
    o_flags = 2'h0;
  end

  // Next byte only after the adapter has taken the last one
  task put(input logic [7:0] b);
    @(posedge i_clock);
    o_wr    <= 1'b1;
    o_wdata <= b;
    @(posedge i_clock);
    o_wr    <= 1'b0;
    o_wdata <= ~b;
    do begin
      @(posedge i_clock);
      saw_full |= i_full;
    end while (i_full);
  endtask

  task send(input logic [7:0] code, input int len, input int tadj);
    int i;
    saw_full = 1'b0;
    put(code);
    put(len[7:0]);
    for (i = 0; i < len; i++) begin
      put(8'($random(seed)));
    end
    put(8'(len + 2 + tadj));
    @(posedge i_clock);
    o_flags <= 2'h3;
  endtask

  task answer(output logic [1:0] ans);
    int n;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (i_asf == 2'h0 && n < 20);
    ans = i_asf;
    @(posedge i_clock);
    o_flags <= 2'h0;
  endtask

  task get(output logic [7:0] b);
    @(posedge i_clock);
    o_rd <= 1'b1;
    @(posedge i_clock);
    o_rd <= 1'b0;
    @(posedge i_clock);
    b = i_rdata;
  endtask

  task flag(input logic [1:0] f);
    @(posedge i_clock);
    o_flags <= f;
  endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench of the command block interpreter
`timescale 1ns/1ps
module testbench;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        h_wr;
  logic [7:0]  h_wdata;
  logic        h_rd;
  logic [7:0]  h_rdata;
  logic [1:0]  hflags;
  logic [1:0]  asf;
  logic        full;
  logic        empty;
  logic        cmd_valid;
  logic [7:0]  cmd_code;
  logic [7:0]  cmd_len;
  logic        cmd_nr;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  b;
  logic [7:0]  v_code;
  logic [7:0]  v_len;
  logic        v_nr;
  int          v_cnt;
  int          exp_stat;
  int          num_errors;
  int          check_count;
  int          c;

  cbi_top uut (
    .i_clock(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_host_wr(h_wr), .i_host_wdata(h_wdata), .i_host_rd(h_rd),
    .o_host_rdata(h_rdata), .i_host_sync_flag_a(hflags[0]),
    .i_host_sync_flag_b(hflags[1]), .o_adapter_sync_flag_a(asf[0]),
    .o_adapter_sync_flag_b(asf[1]), .o_host_cmd_full(full),
    .o_adapter_cmd_empty(empty), .o_cmd_valid(cmd_valid),
    .o_cmd_code(cmd_code), .o_cmd_len(cmd_len),
    .o_cmd_no_resp(cmd_nr), .o_irq(irq));

  cbi_host_model host (
    .i_clock(clk), .i_full(full), .i_rdata(h_rdata), .i_asf(asf),
    .o_wr(h_wr), .o_wdata(h_wdata), .o_rd(h_rd), .o_flags(hflags));

  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    if (cmd_valid === 1'b1) begin
      v_cnt  <= v_cnt + 1;
      v_code <= cmd_code;
      v_len  <= cmd_len;
      v_nr   <= cmd_nr;
    end
  end

  task give_verdict;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
    @(negedge clk);
  endtask

  // Reference: accept only defined codes, bounded length, right total
  task blk(input logic [7:0] k, input int len, input int tadj);
    logic [1:0] ans;
    int         ok;
    int         n0;
    ok = (k >= 8'h01 && k <= 8'h11 && len <= 62 && tadj == 0);
    n0 = v_cnt;
    host.send(k, len, tadj);
    chk("early valid", n0, v_cnt);
    host.answer(ans);
    chk("full seen", 1, host.saw_full);
    chk("answer flags", ok ? 1 : 2, ans);
    chk("valid pulses", ok, v_cnt - n0);
    if (ok) begin
      chk("code", k, v_code);
      chk("length", len, v_len);
      chk("no response", k >= 8'h04 && k <= 8'h07, v_nr);
    end
    exp_stat |= ok ? 1 : 2;
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {v_cnt, exp_stat, num_errors, check_count} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("empty", 1, empty);
    chk("full", 0, full);
    chk("flags", 0, asf);
    apb(1'b1, cbi_pkg::A_INT_EN, 32'h1);
    for (c = 0; c <= 8'h12; c++) begin
      blk(c[7:0], $unsigned($random(host.seed)) % 5, 0);
    end
    blk(8'h2f, 1, 0);
    blk(8'h01, 62, 0);
    apb(1'b0, cbi_pkg::A_LAST_CMD, 32'h0);
    chk("last command", 32'h3e01, rd);
    blk(8'h09, 3, 1);
    blk(8'h02, 2, -1);
    chk("irq", 1, irq);
    apb(1'b0, cbi_pkg::A_INT_STAT, 32'h0);
    chk("int status", exp_stat, rd);
    apb(1'b1, cbi_pkg::A_INT_CLR, 32'h1);
    chk("irq masked", 0, irq);
    apb(1'b1, cbi_pkg::A_INT_EN, 32'hc);
    apb(1'b1, cbi_pkg::A_INT_CLR, 32'hf);
    exp_stat = 0;
    apb(1'b1, cbi_pkg::A_SEND, 32'h20);
    chk("bad code refused", 1, err);
    for (c = 1; c <= 2; c++) begin
      apb(1'b1, cbi_pkg::A_SEND, c == 1 ? 32'h34 : 32'h35);
      chk("send taken", 0, err);
      chk("empty cleared", 0, empty);
      apb(1'b1, cbi_pkg::A_SEND, 32'h0);
      chk("busy refused", 1, err);
      host.get(b);
      chk("adapter code", c == 1 ? 8'h34 : 8'h35, b);
      chk("empty set", 1, empty);
      apb(1'b1, cbi_pkg::A_SEND, 32'h0);
      host.get(b);
      apb(1'b1, cbi_pkg::A_SEND, 32'h2);
      host.get(b);
      chk("total byte", 8'h02, b);
      apb(1'b1, cbi_pkg::A_SEND_CTL, 32'h1);
      chk("end flags", 3, asf);
      host.flag(c[1:0]);
      repeat (3) @(negedge clk);
      host.flag(2'h0);
      exp_stat |= 1 << (c + 1);
    end
    apb(1'b0, cbi_pkg::A_INT_STAT, 32'h0);
    chk("host answers", exp_stat, rd);
    chk("irq events", 1, irq);
    apb(1'b1, cbi_pkg::A_INT_CLR, 32'hf);
    chk("irq cleared", 0, irq);
    apb(1'b0, 8'hfc, 32'h0);
    chk("unmapped", 1, err);
    apb(1'b0, cbi_pkg::A_STATUS, 32'h0);
    chk("status", 2'b01, rd[1:0]);
    give_verdict();
  end

  initial begin
    #500000;
    num_errors++;
    give_verdict();
  end
endmodule
